// ===== verilog/fpc_regs.vh
// Register offsets, fields and constants of the flash protection checker.
`ifndef FPC_REGS_VH
`define FPC_REGS_VH
// ************************************************************
// Register word offsets (byte addresses)
// ************************************************************
`define FPC_CTRL_OFS      8'h00
`define FPC_STAT_OFS      8'h04
`define FPC_OPT_BK0_OFS   8'h08
`define FPC_OPT_MISC_OFS  8'h0c
`define FPC_OPT_SEC_OFS   8'h10
`define FPC_LIVE_BK0_OFS  8'h14
`define FPC_LIVE_MISC_OFS 8'h18
`define FPC_LEVEL_OFS     8'h1c
// ************************************************************
// Control register fields
// ************************************************************
`define FPC_CTRL_ERROR_INTERRUPT_ENABLE    0
`define FPC_CTRL_RELOAD   1
// ************************************************************
// Status register fields
// ************************************************************
`define FPC_STAT_WRITE_PROTECT_ERROR_FLAG    0
`define FPC_STAT_BUSERR   1
`define FPC_STAT_MASSERA  2
`define FPC_STAT_UNPROT   3
// ************************************************************
// Misc option word layout: bank1, data flash, eeprom, partition
// ************************************************************
`define FPC_MISC_BK1_LSB  0
`define FPC_MISC_DF_LSB   8
`define FPC_MISC_EP_LSB   16
`define FPC_MISC_EF_LSB   24
// ************************************************************
// Security word values and levels
// ************************************************************
`define FPC_SEC_NONE      16'h5aa5
`define FPC_SEC_HIGH      16'h33cc
`define FPC_LVL_NONE      2'h0
`define FPC_LVL_LOW       2'h1
`define FPC_LVL_HIGH      2'h2
// ************************************************************
// Partition codes with six data flash slices
// ************************************************************
`define FPC_EF_SIX_A      4'h3
`define FPC_EF_SIX_B      4'hc
`define FPC_EF_SIX_C      4'he
// ************************************************************
// Slices per region
// ************************************************************
`define FPC_BK0_SLICES    32'h20
`define FPC_EIGHTHS       32'h8
`define FPC_SIXTHS        32'h6
// ************************************************************
// Regions and operations
// ************************************************************
`define FPC_RG_BANK0      3'h0
`define FPC_RG_BANK1      3'h1
`define FPC_RG_OTP        3'h2
`define FPC_RG_DFLASH     3'h3
`define FPC_RG_EEPROM     3'h4
`define FPC_RG_OPTION     3'h5
`define FPC_OP_PROG       2'h0
`define FPC_OP_ERASE      2'h1
`define FPC_OP_BLANK      2'h2
`define FPC_OP_SECPROG    2'h3
// ************************************************************
// Reset values
// ************************************************************
`define FPC_RST_BK0       32'hffffffff
`define FPC_RST_MISC      32'hf0ffffff
`define FPC_RST_SEC       16'h5aa5
`endif

// ===== verilog/fpc_checker.v
// Flash erase, program and read protection checker.
`timescale 1ns/1ps
`include "fpc_regs.vh"

module fpc_checker (
	// Clock and reset.
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave.
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Flash operation request from the controller core.
	input  wire        op_valid_i,
	input  wire [1:0]  op_kind_i,
	input  wire [2:0]  op_region_i,
	input  wire [15:0] op_offset_i,
	input  wire [15:0] op_sec_value_i,
	output wire        op_allow_o,
	// Bus read check.
	input  wire        rd_valid_i,
	input  wire [2:0]  rd_region_i,
	output wire        rd_bus_error_o,
	// Boot and debug context pins.
	input  wire        debug_mode_i,
	input  wire        boot_sram_i,
	input  wire        boot_loader_i,
	// Region sizes.
	input  wire [15:0] bank0_size_i,
	input  wire [15:0] bank1_size_i,
	input  wire [15:0] dflash_size_i,
	input  wire [15:0] eeprom_size_i,
	// Results.
	output reg         mass_erase_o,
	output wire        debug_disable_o,
	output wire        error_irq_o
);

	// ************************************************************
	// Context synchronisers
	// ************************************************************
	reg [2:0] ctx_meta;
	reg [2:0] ctx_sync;

	// Debug and boot pins pass two flops before any use.
	// Only the second stage feeds the checks, so a pin change is seen
	// two cycles later.
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctx_meta <= 3'h0;
			ctx_sync <= 3'h0;
		end else begin
			ctx_meta <= {boot_loader_i, boot_sram_i, debug_mode_i};
			ctx_sync <= ctx_meta;
		end
	end

	// ************************************************************
	// Option staging and live latches
	// ************************************************************
	// Staged option words, live latches, level and flags.
	reg [31:0] opt_bk0;
	reg [31:0] opt_misc;
	reg [15:0] opt_sec;
	reg [31:0] live_bk0;
	reg [31:0] live_misc;
	reg [1:0]  level;
	reg        prot_off;
	reg        error_irq_en;
	reg        wp_err;
	reg        bus_err;
	reg        load_pend;
	wire       reload_req;

	// Fields of the live misc word.
	wire [7:0] bank1_protect_bits = live_misc[`FPC_MISC_BK1_LSB +: 8];
	wire [7:0] dflash_protect_bits = live_misc[`FPC_MISC_DF_LSB +: 8];
	wire [7:0] eeprom_protect_bits = live_misc[`FPC_MISC_EP_LSB +: 8];
	wire [3:0] ext_part_code = live_misc[`FPC_MISC_EF_LSB +: 4];

	// Level decoded from a security word.
	// Only the two exact words pick none or high; all else is low.
	function [1:0] fpc_level;
		input [15:0] word;
		begin
			if (word == `FPC_SEC_NONE)
				fpc_level = `FPC_LVL_NONE;
			else if (word == `FPC_SEC_HIGH)
				fpc_level = `FPC_LVL_HIGH;
			else
				fpc_level = `FPC_LVL_LOW;
		end
	endfunction

	// ************************************************************
	// Slice selection
	// ************************************************************
	// Slice arithmetic shared by the bank, data flash and eeprom regions.
	wire       six_mode;
	wire [7:0] dflash_used_bits;
	reg  [4:0] slice;
	reg        guarded;
	reg  [31:0] prod;
	reg  [31:0] quot;

	assign six_mode = (ext_part_code == `FPC_EF_SIX_A) ||
		(ext_part_code == `FPC_EF_SIX_B) ||
		(ext_part_code == `FPC_EF_SIX_C);

	// In six-slice mode the two top data flash bits guard nothing.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_df_bit
			assign dflash_used_bits[gi] = (six_mode && gi >= 6) ?
				1'b1 : dflash_protect_bits[gi];
		end
	endgenerate

	// Slice index is offset times slices over region size.
	// A zero size selects slice 0 rather than dividing by zero.
	// Offsets past the region end wrap; the core never sends them.
	always @* begin
		prod = 32'h0;
		quot = 32'h0;
		slice = 5'h0;
		guarded = 1'b0;
		case (op_region_i)
		`FPC_RG_BANK0: begin
			prod = {16'h0, op_offset_i} * `FPC_BK0_SLICES;
			if (bank0_size_i != 16'h0)
				quot = prod / {16'h0, bank0_size_i};
			slice = quot[4:0];
			guarded = ~live_bk0[slice];
		end
		`FPC_RG_BANK1: begin
			prod = {16'h0, op_offset_i} * `FPC_EIGHTHS;
			if (bank1_size_i != 16'h0)
				quot = prod / {16'h0, bank1_size_i};
			slice = quot[4:0];
			guarded = ~bank1_protect_bits[slice[2:0]];
		end
		`FPC_RG_OTP: begin
			guarded = ~bank1_protect_bits[7];
		end
		`FPC_RG_DFLASH: begin
			prod = {16'h0, op_offset_i} *
				(six_mode ? `FPC_SIXTHS : `FPC_EIGHTHS);
			if (dflash_size_i != 16'h0)
				quot = prod / {16'h0, dflash_size_i};
			slice = quot[4:0];
			guarded = ~dflash_used_bits[slice[2:0]];
		end
		`FPC_RG_EEPROM: begin
			prod = {16'h0, op_offset_i} * `FPC_EIGHTHS;
			if (eeprom_size_i != 16'h0)
				quot = prod / {16'h0, eeprom_size_i};
			slice = quot[4:0];
			guarded = ~eeprom_protect_bits[slice[2:0]];
		end
		default: begin
			guarded = 1'b0;
		end
		endcase
	end

	// ************************************************************
	// Operation decision
	// ************************************************************
	// Any boot or debug context counts as untrusted once synchronised.
	// The option page is left out of page protection so that a part
	// below high level can be recovered. A blank check only reads the array, so
	// only the context rule at low level can refuse it. At high level
	// a security word program is refused whatever region it names.
	wire untrusted = |ctx_sync;
	wire is_option = (op_region_i == `FPC_RG_OPTION);
	wire wp_hit = guarded && !prot_off && !is_option;
	wire low_hit = (level == `FPC_LVL_LOW) && untrusted &&
		!is_option;
	wire high_hit = (level == `FPC_LVL_HIGH) &&
		((is_option && (op_kind_i == `FPC_OP_ERASE)) ||
		(op_kind_i == `FPC_OP_SECPROG));
	wire blank_op = (op_kind_i == `FPC_OP_BLANK);
	wire deny = blank_op ? low_hit : (wp_hit || low_hit || high_hit);
	wire op_take = op_valid_i && !deny;

	// Answers are combinational so the core sees them in its cycle.
	assign op_allow_o = op_valid_i && !deny;
	assign rd_bus_error_o = rd_valid_i && (level == `FPC_LVL_LOW) &&
		untrusted && (rd_region_i == `FPC_RG_BANK0 ||
		rd_region_i == `FPC_RG_BANK1);
	assign debug_disable_o = (level == `FPC_LVL_HIGH);
	assign error_irq_o = wp_err && error_irq_en;

	// ************************************************************
	// Wishbone slave
	// ************************************************************
	// A request is taken once; the registered ack masks it next cycle
	// so a strobe held until the ack edge is never taken twice.
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;
	wire ctrl_wr = wb_wr && (wb_adr_i == `FPC_CTRL_OFS) && wb_sel_i[0];
	wire stat_wr = wb_wr && (wb_adr_i == `FPC_STAT_OFS) && wb_sel_i[0];
	assign reload_req = ctrl_wr && wb_dat_i[`FPC_CTRL_RELOAD];

	// Ack one cycle after the strobe; read data from flops.
	// Unmapped addresses read as zero and ignore writes.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
				`FPC_CTRL_OFS: wb_dat_o <= {31'h0, error_irq_en};
				`FPC_STAT_OFS: wb_dat_o <= {28'h0, prot_off,
					mass_erase_o, bus_err, wp_err};
				`FPC_OPT_BK0_OFS: wb_dat_o <= opt_bk0;
				`FPC_OPT_MISC_OFS: wb_dat_o <= opt_misc;
				`FPC_OPT_SEC_OFS: wb_dat_o <= {16'h0, opt_sec};
				`FPC_LIVE_BK0_OFS: wb_dat_o <= live_bk0;
				`FPC_LIVE_MISC_OFS: wb_dat_o <= live_misc;
				`FPC_LEVEL_OFS: wb_dat_o <= {30'h0, level};
				default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// ************************************************************
	// Option staging, latches and flags
	// ************************************************************
	wire opt_bk0_wr = wb_wr && (wb_adr_i == `FPC_OPT_BK0_OFS);
	wire opt_misc_wr = wb_wr && (wb_adr_i == `FPC_OPT_MISC_OFS);
	wire opt_sec_wr = wb_wr && (wb_adr_i == `FPC_OPT_SEC_OFS) &&
		(level != `FPC_LVL_HIGH);
	wire [1:0] next_level = fpc_level(opt_sec);
	wire wp_set = op_valid_i && deny;
	wire latch_now = load_pend || reload_req;
	wire opt_erase = op_take && is_option &&
		(op_kind_i == `FPC_OP_ERASE);

	// Mass erase starts when security drops from low to none, either by
	// a security word program or by a reload of the staged word.
	wire sec_drop = op_take && (op_kind_i == `FPC_OP_SECPROG) &&
		(level == `FPC_LVL_LOW) &&
		(op_sec_value_i == `FPC_SEC_NONE);
	wire reload_drop = latch_now && !load_pend &&
		(level == `FPC_LVL_LOW) && (next_level == `FPC_LVL_NONE);
	wire mass_set = sec_drop || reload_drop;

	// The write-protect, bus error and mass erase flags clear by writing one to their bit.
	wire wp_clr = stat_wr && wb_dat_i[`FPC_STAT_WRITE_PROTECT_ERROR_FLAG];
	wire bus_clr = stat_wr && wb_dat_i[`FPC_STAT_BUSERR];
	wire mass_clr = stat_wr && wb_dat_i[`FPC_STAT_MASSERA];

	// Staged option words stand for the option bytes.
	// Security writes are dropped at high level so it cannot be lowered.
	always @(posedge clk_i) begin
		if (rst_i) begin
			opt_bk0 <= `FPC_RST_BK0;
			opt_misc <= `FPC_RST_MISC;
			opt_sec <= `FPC_RST_SEC;
		end else begin
			if (opt_bk0_wr)
				opt_bk0 <= wb_dat_i;
			if (opt_misc_wr)
				opt_misc <= wb_dat_i;
			if (opt_sec_wr)
				opt_sec <= wb_dat_i[15:0];
		end
	end

	// Live latches load once after reset and on each reload trigger.
	// Staged edits leave the checks untouched until then.
	always @(posedge clk_i) begin
		if (rst_i) begin
			live_bk0 <= `FPC_RST_BK0;
			live_misc <= `FPC_RST_MISC;
			level <= `FPC_LVL_NONE;
			load_pend <= 1'b1;
		end else begin
			load_pend <= 1'b0;
			if (latch_now) begin
				live_bk0 <= opt_bk0;
				live_misc <= opt_misc;
				level <= next_level;
			end
		end
	end

	// Interrupt enable bit of the control register.
	always @(posedge clk_i) begin
		if (rst_i) begin
			error_irq_en <= 1'b0;
		end else if (ctrl_wr) begin
			error_irq_en <= wb_dat_i[`FPC_CTRL_ERROR_INTERRUPT_ENABLE];
		end
	end

	// Option erase lifts page protection until the next latch load.
	// An erase in the same cycle as a reload wins.
	always @(posedge clk_i) begin
		if (rst_i) begin
			prot_off <= 1'b0;
		end else if (opt_erase) begin
			prot_off <= 1'b1;
		end else if (latch_now) begin
			prot_off <= 1'b0;
		end
	end

	// Write-protect error flag.
	// A new refusal in the same cycle as a clear wins.
	always @(posedge clk_i) begin
		if (rst_i) begin
			wp_err <= 1'b0;
		end else if (wp_set) begin
			wp_err <= 1'b1;
		end else if (wp_clr) begin
			wp_err <= 1'b0;
		end
	end

	// Bus error flag for refused reads.
	// A new refused read in the same cycle as a clear wins.
	always @(posedge clk_i) begin
		if (rst_i) begin
			bus_err <= 1'b0;
		end else if (rd_bus_error_o) begin
			bus_err <= 1'b1;
		end else if (bus_clr) begin
			bus_err <= 1'b0;
		end
	end

	// Mass erase request stays up until software clears it.
	// A drop to no protection in the same cycle as a clear wins.
	always @(posedge clk_i) begin
		if (rst_i) begin
			mass_erase_o <= 1'b0;
		end else if (mass_set) begin
			mass_erase_o <= 1'b1;
		end else if (mass_clr) begin
			mass_erase_o <= 1'b0;
		end
	end

endmodule // fpc_checker

// ===== dv/fpc_checker_monitor.sv
// Port-level assertions for the flash protection checker.
`timescale 1ns/1ps
`include "fpc_regs.vh"
module fpc_checker_monitor (
	// Clock and reset.
	input wire        clk_i,
	input wire        rst_i,
	// Bus and request inputs.
	input wire        wb_cyc_i,
	input wire        wb_we_i,
	input wire        op_valid_i,
	input wire [1:0]  op_kind_i,
	input wire [2:0]  op_region_i,
	input wire [15:0] op_sec_value_i,
	input wire        rd_valid_i,
	input wire [2:0]  rd_region_i,
	// Checker outputs.
	input wire        op_allow_o,
	input wire        rd_bus_error_o,
	input wire        mass_erase_o,
	input wire        debug_disable_o,
	input wire        error_irq_o
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A security word request; p_nosec adds the high protection condition.
	sequence s_sec;
		op_valid_i && op_kind_i == `FPC_OP_SECPROG;
	endsequence
	property p_allow;
		op_allow_o |-> op_valid_i;
	endproperty
	a_allow: assert property (p_allow)
		else $error("Allow without a request.");
	property p_keep;
		error_irq_o && !wb_cyc_i |=> error_irq_o;
	endproperty
	a_keep: assert property (p_keep)
		else $error("Error flag lost without a bus write.");
	property p_irq;
		$rose(error_irq_o) |-> $past(op_valid_i && !op_allow_o
			|| wb_cyc_i && wb_we_i);
	endproperty
	a_irq: assert property (p_irq)
		else $error("Interrupt rose without a refused request.");
	property p_rderr;
		rd_bus_error_o |-> rd_valid_i && !debug_disable_o
			&& rd_region_i <= `FPC_RG_BANK1;
	endproperty
	a_rderr: assert property (p_rderr)
		else $error("Bus error outside a main flash read.");
	property p_opt;
		op_valid_i && op_region_i == `FPC_RG_OPTION && !debug_disable_o
			&& op_kind_i != `FPC_OP_SECPROG |-> op_allow_o;
	endproperty
	a_opt: assert property (p_opt)
		else $error("Option byte request refused.");
	property p_mass;
		$rose(mass_erase_o) |-> !debug_disable_o && $past(op_valid_i
			&& op_sec_value_i == `FPC_SEC_NONE || wb_cyc_i && wb_we_i);
	endproperty
	a_mass: assert property (p_mass)
		else $error("Mass erase without a drop to no protection.");
	property p_stay;
		debug_disable_o |=> debug_disable_o;
	endproperty
	a_stay: assert property (p_stay)
		else $error("High protection was lowered.");
	property p_nosec;
		debug_disable_o ##0 s_sec |-> !op_allow_o;
	endproperty
	a_nosec: assert property (p_nosec)
		else $error("Security word accepted at high level.");
	property p_noopt;
		debug_disable_o && op_valid_i && op_kind_i == `FPC_OP_ERASE
			&& op_region_i == `FPC_RG_OPTION |-> !op_allow_o;
	endproperty
	a_noopt: assert property (p_noopt)
		else $error("Option erase accepted at high level.");
endmodule // fpc_checker_monitor

// ===== dv/fpc_core_model.sv
// Core model that issues flash operations and bus reads.
`timescale 1ns/1ps
module fpc_core_model (
	// Clock and answers.
	input  wire        clk_i,
	input  wire        op_allow_i,
	input  wire        rd_bus_error_i,
	// Requests.
	output reg         op_valid_o,
	output reg  [1:0]  op_kind_o,
	output reg  [2:0]  op_region_o,
	output reg  [15:0] op_offset_o,
	output reg  [15:0] op_sec_value_o,
	output reg         rd_valid_o,
	output reg  [2:0]  rd_region_o
);
	// Idle at time zero.
	initial begin
		op_valid_o = 1'b0;
		op_kind_o = 2'h0;
		op_region_o = 3'h0;
		op_offset_o = 16'h0;
		op_sec_value_o = 16'h0;
		rd_valid_o = 1'b0;
		rd_region_o = 3'h0;
	end
	// One request set after an edge, answered at the next rising edge.
	task go(input r, input [1:0] k, input [2:0] g, input [15:0] o,
		input [15:0] s, output a);
		begin
			@(posedge clk_i);
			op_valid_o <= !r;
			rd_valid_o <= r;
			op_kind_o <= k;
			op_region_o <= g;
			rd_region_o <= g;
			op_offset_o <= o;
			op_sec_value_o <= s;
			@(posedge clk_i);
			a = r ? rd_bus_error_i : op_allow_i;
			op_valid_o <= 1'b0;
			rd_valid_o <= 1'b0;
			op_offset_o <= ~o;
		end
	endtask
endmodule // fpc_core_model

// ===== dv/tb.sv
// Self-checking bench for the flash protection checker.
`timescale 1ns/1ps
`include "fpc_regs.vh"
module tb;
	reg         clk_i, rst_i, cyc, we, dbg, bsram, bldr;
	reg  [7:0]  adr;
	reg  [31:0] wdat, rdat;
	wire [31:0] dat_o;
	wire        ack, vld, rvld, allow, berr, mass, ddis, irq;
	wire [1:0]  kind;
	wire [2:0]  rg, rrg;
	wire [15:0] ofs, secv;
	integer     errors, comparisons, i;
	// ****************
	// Clock, design and core model
	// ****************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Sizes give two-unit bank 0 slices and six-unit data flash eighths.
	fpc_checker i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.op_valid_i(vld), .op_kind_i(kind), .op_region_i(rg),
		.op_offset_i(ofs), .op_sec_value_i(secv), .op_allow_o(allow),
		.rd_valid_i(rvld), .rd_region_i(rrg), .rd_bus_error_o(berr),
		.debug_mode_i(dbg), .boot_sram_i(bsram), .boot_loader_i(bldr),
		.bank0_size_i(16'h40), .bank1_size_i(16'h40),
		.dflash_size_i(16'h30), .eeprom_size_i(16'h40),
		.mass_erase_o(mass), .debug_disable_o(ddis), .error_irq_o(irq));
	fpc_core_model i_core (.clk_i(clk_i), .op_allow_i(allow),
		.rd_bus_error_i(berr), .op_valid_o(vld), .op_kind_o(kind),
		.op_region_o(rg), .op_offset_o(ofs), .op_sec_value_o(secv),
		.rd_valid_o(rvld), .rd_region_o(rrg));
	// Verdict and end of run.
	task tally_and_finish;
		begin
			$display("errors %0d comparisons %0d", errors, comparisons);
			if (errors == 0 && comparisons > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [8*5:1] n, input [31:0] e, input [31:0] s);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				errors = errors + 1;
				$display("[FAIL] %0s exp %h got %h", n, e, s);
			end
		end
	endtask
	// Classic single bus cycle held until the rising edge with ack high.
	task bus(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk_i);
			cyc <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= d;
			n = 0;
			@(posedge clk_i);
			while (ack !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge clk_i);
			end
			if (ack !== 1'b1) begin
				errors = errors + 1;
				$display("[FAIL] ack exp 1 got %b", ack);
				tally_and_finish;
			end
			rdat = dat_o;
			cyc <= 1'b0;
			we <= 1'b0;
		end
	endtask
	task rchk(input [7:0] a, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk("reg", e, rdat);
		end
	endtask
	task op(input r, input [1:0] k, input [2:0] g, input [15:0] o,
		input [15:0] s, input e);
		reg a;
		begin
			i_core.go(r, k, g, o, s, a);
			chk("op", {31'h0, e}, {31'h0, a});
		end
	endtask
	// Main sequence.
	initial begin
		errors = 0;
		comparisons = 0;
		{cyc, we, dbg, bsram, bldr} = 5'h0;
		adr = 8'h0;
		wdat = 32'h0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(`FPC_OPT_BK0_OFS, `FPC_RST_BK0);
		rchk(`FPC_OPT_MISC_OFS, `FPC_RST_MISC);
		rchk(`FPC_OPT_SEC_OFS, {16'h0, `FPC_RST_SEC});
		rchk(`FPC_LEVEL_OFS, 32'h0);
		rchk(8'h20, 32'h0);
		bus(1'b1, `FPC_OPT_BK0_OFS, 32'hfffffffe);
		bus(1'b1, `FPC_OPT_MISC_OFS, 32'h0ffe7f7f);
		op(0, 0, 0, 16'h0, 16'h0, 1);
		bus(1'b1, `FPC_CTRL_OFS, 32'h3);
		op(0, 0, 0, 16'h0, 16'h0, 0);
		op(0, 1, 0, 16'h2, 16'h0, 1);
		op(0, 0, 1, 16'h37, 16'h0, 1);
		op(0, 1, 1, 16'h38, 16'h0, 0);
		op(0, 0, 2, 16'h0, 16'h0, 0);
		op(0, 0, 4, 16'h0, 16'h0, 0);
		op(0, 0, 4, 16'h8, 16'h0, 1);
		op(0, 0, 3, 16'h2a, 16'h0, 0);
		op(0, 0, 3, 16'h29, 16'h0, 1);
		rchk(`FPC_STAT_OFS, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, `FPC_STAT_OFS, 32'h7);
		@(negedge clk_i);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, `FPC_OPT_MISC_OFS, 32'h03fedf7f);
		bus(1'b1, `FPC_CTRL_OFS, 32'h3);
		op(0, 0, 3, 16'h28, 16'h0, 0);
		op(0, 0, 3, 16'h27, 16'h0, 1);
		op(0, 1, 5, 16'h0, 16'h0, 1);
		op(0, 0, 0, 16'h0, 16'h0, 1);
		bus(1'b1, `FPC_OPT_SEC_OFS, 32'h1234);
		bus(1'b1, `FPC_CTRL_OFS, 32'h3);
		rchk(`FPC_LEVEL_OFS, 32'h1);
		for (i = 0; i < 3; i = i + 1) begin
			{bldr, bsram, dbg} <= 3'h1 << i;
			repeat (3) @(posedge clk_i);
			op(0, 2, 3, 16'h0, 16'h0, 0);
			op(1, 0, 0, 16'h0, 16'h0, 1);
			op(0, 0, 5, 16'h0, 16'h0, 1);
		end
		{bldr, bsram, dbg} <= 3'h0;
		repeat (3) @(posedge clk_i);
		op(0, 2, 3, 16'h0, 16'h0, 1);
		op(1, 0, 0, 16'h0, 16'h0, 0);
		op(0, 3, 5, 16'h0, `FPC_SEC_NONE, 1);
		@(negedge clk_i);
		chk("mass", 32'h1, {31'h0, mass});
		bus(1'b1, `FPC_OPT_SEC_OFS, {16'h0, `FPC_SEC_HIGH});
		bus(1'b1, `FPC_CTRL_OFS, 32'h3);
		rchk(`FPC_LEVEL_OFS, 32'h2);
		chk("ddis", 32'h1, {31'h0, ddis});
		op(0, 3, 5, 16'h0, `FPC_SEC_NONE, 0);
		op(0, 1, 5, 16'h0, 16'h0, 0);
		op(0, 0, 0, 16'h4, 16'h0, 1);
		tally_and_finish;
	end
endmodule // tb
bind fpc_checker fpc_checker_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i), .op_valid_i(op_valid_i),
	.op_kind_i(op_kind_i), .op_region_i(op_region_i),
	.op_sec_value_i(op_sec_value_i), .rd_valid_i(rd_valid_i),
	.rd_region_i(rd_region_i), .op_allow_o(op_allow_o),
	.rd_bus_error_o(rd_bus_error_o), .mass_erase_o(mass_erase_o),
	.debug_disable_o(debug_disable_o), .error_irq_o(error_irq_o));
